// File: verification/ptb_time_base_properties.sv
// assertion checker for the pwm time base ports
`timescale 1ns/100ps
module ptb_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire irq,
  input wire [14:0] count_out,
  input wire count_down_flag
);
  // ************
  // properties
  // ************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  property p_ready; s_access |=> s_answer; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_rdata; !pready |-> prdata == 32'h0; endproperty
  property p_dir_rise;
    $rose(count_down_flag) && !$past(psel) |-> count_out == $past(count_out) - 15'h1;
  endproperty
  property p_down;
    count_down_flag && $past(count_down_flag) && $changed(count_out) && !$past(psel)
      |-> count_out == $past(count_out) - 15'h1;
  endproperty
  property p_up;
    !count_down_flag && !$past(count_down_flag) && $changed(count_out) && !$past(psel)
      |-> count_out == $past(count_out) + 15'h1 || count_out == 15'h0;
  endproperty
  property p_tick;
    $changed(count_out) && !$past(psel) |=> ($stable(count_out) || $past(psel)) [*3];
  endproperty
  property p_irq_hold; irq && !psel |=> irq; endproperty
  a_ready: assert property (p_ready) else $error("answer not one wait state");
  a_err: assert property (p_err) else $error("error without ready");
  a_rdata: assert property (p_rdata) else $error("read data outside answer");
  a_dir_rise: assert property (p_dir_rise) else $error("bad turn step");
  a_down: assert property (p_down) else $error("bad down step");
  a_up: assert property (p_up) else $error("bad up step");
  a_tick: assert property (p_tick) else $error("ticks too close");
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped by itself");
endmodule // ptb_checker
bind ptb_time_base ptb_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .count_out(count_out), .count_down_flag(count_down_flag));

// File: verification/tb.sv
// self-checking bench for the pwm time base
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests = n_tests + 1; if ((a) !== (e)) begin \
  n_mismatch = n_mismatch + 1; $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module tb;
  // ************
  // stimulus
  // ************
  reg pclk, presetn, psel, penable, pwrite, er, irq_q;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd, s;
  wire [31:0] prdata;
  wire pready, pslverr, irq, dn;
  wire [14:0] cnt;
  integer n_mismatch = 0, n_tests = 0, cyc = 0, nev = 0, i, j, k, b, p, pre, ev;
  integer ts[0:63];
  reg [1:0] md, ck;
  reg [3:0] ops;
  ptb_time_base dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .count_out(cnt), .count_down_flag(dn));
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    irq_q <= irq;
    if (irq && !irq_q) begin
      ts[nev] <= cyc;
      nev <= nev + 1;
    end
  end
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      k = 0;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 20) begin
        @(posedge pclk);
        k = k + 1;
      end
      if (k == 20) n_mismatch = n_mismatch + 1;
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
    end
  endtask
  task stop_test;
    begin
      $display("mismatches %0d, checks %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (90000) @(posedge pclk);
    n_mismatch = n_mismatch + 1;
    stop_test;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
    p = $urandom(12118);
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (i = 0; i < 24; i = i + 4) begin
      apb(0, i, 0);
      `CHK(rd, 32'h0)
    end
    apb(1, 12'h100, 1);
    `CHK(er, 1'b1)
    apb(1, 4, 32'hffff);
    apb(1, 0, 2);
    apb(0, 4, 0);
    `CHK(rd, 32'h7fff)
    apb(1, 4, 0);
    apb(1, 0, 32'h8000);
    repeat (100) @(posedge pclk);
    `CHK(cnt, 15'h0)
    apb(1, 8, 5);
    repeat (100) @(posedge pclk);
    `CHK(cnt + nev, 15'h0)
    apb(1, 0, 0);
    apb(1, 8, 8);
    apb(1, 0, 32'h8000);
    repeat (200) @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(0, 12'h00c, 0);
    `CHK(rd, 32'h1)
    apb(1, 12'h010, 1);
    `CHK(irq, 1'b1)
    for (i = 0; i < 8; i = i + 1) begin
      md = i;
      ck = (i == 7) ? 3 : $urandom % 2;
      ops = (i == 4) ? 15 : $urandom % 4;
      p = 8 + $urandom % 8;
      pre = 1 << (2 * ck);
      ev = md == 0 ? (p + 1) * 4 * pre * (ops + 1) : md == 2 ? 8 * p * pre * (ops + 1) : 4 * p * pre;
      apb(1, 0, 0);
      apb(1, 4, 0);
      apb(1, 8, p);
      apb(1, 12'h014, 1);
      b = nev;
      apb(1, 0, {16'h0, 1'b1, 7'h0, ops, ck, md});
      for (j = 1; j <= 3; j = j + 1) begin
        k = 0;
        while (nev < b + j && k < 3 * ev + 200) begin
          @(posedge pclk);
          k = k + 1;
        end
        apb(1, 12'h014, 1);
      end
      if (md == 1) begin
        `CHK(nev - b, 1)
        apb(0, 0, 0);
        `CHK(rd[15], 1'b0)
        apb(0, 4, 0);
        `CHK(rd, 32'h0)
      end else `CHK(ts[b + 2] - ts[b], 2 * ev)
    end
    apb(1, 0, 0);
    apb(0, 4, 0);
    s = rd;
    repeat (50) @(posedge pclk);
    apb(0, 4, 0);
    `CHK(rd, s)
    stop_test;
  end
endmodule // tb

// File: verilog/ptb_map.vh
// register offsets, field positions and reset values of the pwm time base
`ifndef PTB_MAP_VH
`define PTB_MAP_VH
`define PTB_OFS_CONTROL 12'h000
`define PTB_OFS_COUNTER 12'h004
`define PTB_OFS_PERIOD 12'h008
`define PTB_OFS_INT_STATUS 12'h00c
`define PTB_OFS_INT_ENABLE 12'h010
`define PTB_OFS_INT_CLEAR 12'h014
`define PTB_CTL_EN_BIT 15
`define PTB_CTL_OPS_HI 7
`define PTB_CTL_OPS_LO 4
`define PTB_CTL_CKPS_HI 3
`define PTB_CTL_CKPS_LO 2
`define PTB_CTL_MOD_HI 1
`define PTB_CTL_MOD_LO 0
`define PTB_MODE_FREE 2'h0
`define PTB_MODE_SINGLE 2'h1
`define PTB_MODE_UPDN 2'h2
`define PTB_MODE_DBL 2'h3
`define PTB_CNT_W 15
`define PTB_RST_COUNT 15'h0000
`define PTB_RST_PERIOD 15'h0000
`define PTB_INST_DIV 2'h3
`define PTB_INT_BIT 0
`endif

// File: verilog/ptb_scaler.v
// prescaler divider that issues the counter input clock tick
`timescale 1ns/100ps
module ptb_scaler (
  input wire pclk,
  input wire presetn,
  input wire clr,
  input wire [1:0] sel,
  input wire in_tick,
  output reg out_tick
);
  reg [5:0] cnt_r;
  reg [5:0] lim;
  always @* begin
    case (sel)
      2'h0: lim = 6'h00;
      2'h1: lim = 6'h03;
      2'h2: lim = 6'h0f;
      default: lim = 6'h3f;
    endcase
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 6'h00;
      out_tick <= 1'b0;
    end else if (clr) begin
      cnt_r <= 6'h00;
      out_tick <= 1'b0;
    end else begin
      out_tick <= 1'b0;
      if (in_tick) begin
        if (cnt_r >= lim) begin
          cnt_r <= 6'h00;
          out_tick <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 6'h01;
        end
      end
    end
  end
endmodule // ptb_scaler

// File: verilog/ptb_time_base.v
// pwm time base with apb registers and interrupt
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/100ps
`include "ptb_map.vh"
module ptb_time_base (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg irq,
  output reg [`PTB_CNT_W-1:0] count_out,
  output reg count_down_flag
);
  // ****************************************
  // registers
  // ****************************************
  reg time_base_enable_r;
  reg [1:0] time_base_mode_sel_r;
  reg [1:0] prescale_sel_r;
  reg [3:0] postscale_sel_r;
  reg [`PTB_CNT_W-1:0] cnt_r;
  reg dir_r;
  reg [`PTB_CNT_W-1:0] period_r;
  reg [`PTB_CNT_W-1:0] period_buf_r;
  reg [1:0] inst_r;
  reg [3:0] post_r;
  reg int_stat_r;
  reg int_en_r;
  reg [31:0] rd_nxt;
  reg err_nxt;
  reg [1:0] inst_nxt;
  reg [3:0] post_nxt;
  reg [`PTB_CNT_W-1:0] cnt_nxt;
  reg dir_nxt;
  reg en_nxt;
  reg [1:0] mode_nxt;
  reg [1:0] pre_sel_nxt;
  reg [3:0] post_sel_nxt;
  reg [`PTB_CNT_W-1:0] buf_nxt;
  reg [`PTB_CNT_W-1:0] per_nxt;
  reg stat_nxt;
  reg ien_nxt;
  // ****************************************
  // bus decode
  // ****************************************
  wire acc = psel & penable & ~pready;
  wire wr = acc & pwrite;
  wire wr_ctl = wr & (paddr == `PTB_OFS_CONTROL);
  wire wr_cnt = wr & (paddr == `PTB_OFS_COUNTER);
  wire wr_per = wr & (paddr == `PTB_OFS_PERIOD);
  wire wr_ien = wr & (paddr == `PTB_OFS_INT_ENABLE);
  wire wr_icl = wr & (paddr == `PTB_OFS_INT_CLEAR);
  wire scale_clr = wr_ctl | wr_cnt;
  // ****************************************
  // input clock and prescaler
  // ****************************************
  wire inst_tick = (inst_r == `PTB_INST_DIV);
  wire tick;
  always @* begin
    inst_nxt = inst_r + 2'h1;
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inst_r <= 2'h0;
    end else begin
      inst_r <= inst_nxt;
    end
  end
  ptb_scaler u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .clr(scale_clr),
    .sel(prescale_sel_r),
    .in_tick(inst_tick),
    .out_tick(tick)
  );
  // ****************************************
  // counter core
  // ****************************************
  wire per_zero = (period_r == 15'h0000);
  wire run = time_base_enable_r & ~per_zero & tick;
  wire match = (cnt_r == period_r);
  wire updn = time_base_mode_sel_r[1];
  wire at_zero = (cnt_r == 15'h0000);
  reg wrap;
  reg turn_up;
  reg raw_ev;
  reg post_ok;
  always @* begin
    wrap = run & match & ~updn;
    turn_up = run & updn & dir_r & (cnt_r == 15'h0001);
    raw_ev = 1'b0;
    post_ok = 1'b0;
    case (time_base_mode_sel_r)
      `PTB_MODE_FREE: begin
        raw_ev = wrap;
        post_ok = 1'b1;
      end
      `PTB_MODE_SINGLE: begin
        raw_ev = wrap;
      end
      `PTB_MODE_UPDN: begin
        raw_ev = turn_up;
        post_ok = 1'b1;
      end
      `PTB_MODE_DBL: begin
        raw_ev = turn_up | (run & match & ~dir_r);
      end
      default: begin
        raw_ev = 1'b0;
      end
    endcase
  end
  // ****************************************
  // postscaler
  // ****************************************
  // bypassed where the mode ignores it
  wire post_hit = (post_r == postscale_sel_r);
  wire ev = raw_ev & (~post_ok | post_hit);
  always @* begin
    post_nxt = post_r;
    if (scale_clr) begin
      post_nxt = 4'h0;
    end else if (raw_ev & post_ok) begin
      if (post_hit) begin
        post_nxt = 4'h0;
      end else begin
        post_nxt = post_r + 4'h1;
      end
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_r <= 4'h0;
    end else begin
      post_r <= post_nxt;
    end
  end
  // ****************************************
  // counter next state
  // ****************************************
  always @* begin
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    if (wr_cnt) begin
      cnt_nxt = pwdata[`PTB_CNT_W-1:0];
    end else if (run) begin
      if (!updn) begin
        dir_nxt = 1'b0;
        if (match) begin
          cnt_nxt = 15'h0000;
        end else begin
          cnt_nxt = cnt_r + 15'h0001;
        end
      end else if (!dir_r) begin
        if (match) begin
          dir_nxt = 1'b1;
          cnt_nxt = cnt_r - 15'h0001;
        end else begin
          cnt_nxt = cnt_r + 15'h0001;
        end
      end else if (at_zero) begin
        dir_nxt = 1'b0;
        cnt_nxt = 15'h0001;
      end else begin
        cnt_nxt = cnt_r - 15'h0001;
        if (cnt_r == 15'h0001) begin
          dir_nxt = 1'b0;
        end
      end
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= `PTB_RST_COUNT;
      dir_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      dir_r <= dir_nxt;
    end
  end
  // ****************************************
  // control and period
  // ****************************************
  wire per_load = ~per_zero & ((wrap) | (updn & run & turn_up) | ~time_base_enable_r);
  always @* begin
    en_nxt = time_base_enable_r;
    mode_nxt = time_base_mode_sel_r;
    pre_sel_nxt = prescale_sel_r;
    post_sel_nxt = postscale_sel_r;
    if (wr_ctl) begin
      en_nxt = pwdata[`PTB_CTL_EN_BIT];
      mode_nxt = pwdata[`PTB_CTL_MOD_HI:`PTB_CTL_MOD_LO];
      pre_sel_nxt = pwdata[`PTB_CTL_CKPS_HI:`PTB_CTL_CKPS_LO];
      post_sel_nxt = pwdata[`PTB_CTL_OPS_HI:`PTB_CTL_OPS_LO];
    end else if (wrap & (time_base_mode_sel_r == `PTB_MODE_SINGLE)) begin
      en_nxt = 1'b0;
    end
  end
  // ****************************************
  // period buffer and active period
  // ****************************************
  always @* begin
    buf_nxt = period_buf_r;
    per_nxt = period_r;
    if (wr_per) begin
      buf_nxt = pwdata[`PTB_CNT_W-1:0];
    end
    if (per_zero) begin
      if (!time_base_enable_r) begin
        per_nxt = period_buf_r;
      end
    end else if (per_load) begin
      per_nxt = period_buf_r;
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      time_base_enable_r <= 1'b0;
      time_base_mode_sel_r <= `PTB_MODE_FREE;
      prescale_sel_r <= 2'h0;
      postscale_sel_r <= 4'h0;
      period_buf_r <= `PTB_RST_PERIOD;
      period_r <= `PTB_RST_PERIOD;
    end else begin
      time_base_enable_r <= en_nxt;
      time_base_mode_sel_r <= mode_nxt;
      prescale_sel_r <= pre_sel_nxt;
      postscale_sel_r <= post_sel_nxt;
      period_buf_r <= buf_nxt;
      period_r <= per_nxt;
    end
  end
  // ****************************************
  // interrupt
  // ****************************************
  always @* begin
    stat_nxt = int_stat_r;
    ien_nxt = int_en_r;
    if (ev) begin
      stat_nxt = 1'b1;
    end else if (wr_icl & pwdata[`PTB_INT_BIT]) begin
      stat_nxt = 1'b0;
    end
    if (wr_ien) begin
      ien_nxt = pwdata[`PTB_INT_BIT];
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_r <= 1'b0;
      int_en_r <= 1'b0;
      irq <= 1'b0;
    end else begin
      int_stat_r <= stat_nxt;
      int_en_r <= ien_nxt;
      irq <= (int_stat_r | ev) & ien_nxt;
    end
  end
  // ****************************************
  // read path and outputs
  // ****************************************
  always @* begin
    rd_nxt = 32'h0000_0000;
    err_nxt = 1'b0;
    case (paddr)
      `PTB_OFS_CONTROL: begin
        rd_nxt[`PTB_CTL_EN_BIT] = time_base_enable_r;
        rd_nxt[`PTB_CTL_OPS_HI:`PTB_CTL_OPS_LO] = postscale_sel_r;
        rd_nxt[`PTB_CTL_CKPS_HI:`PTB_CTL_CKPS_LO] = prescale_sel_r;
        rd_nxt[`PTB_CTL_MOD_HI:`PTB_CTL_MOD_LO] = time_base_mode_sel_r;
      end
      `PTB_OFS_COUNTER: rd_nxt[15:0] = {dir_r, cnt_r};
      `PTB_OFS_PERIOD: rd_nxt[14:0] = period_buf_r;
      `PTB_OFS_INT_STATUS: rd_nxt[`PTB_INT_BIT] = int_stat_r;
      `PTB_OFS_INT_ENABLE: rd_nxt[`PTB_INT_BIT] = int_en_r;
      `PTB_OFS_INT_CLEAR: rd_nxt = 32'h0000_0000;
      default: err_nxt = 1'b1;
    endcase
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc;
      pslverr <= acc & err_nxt;
      prdata <= (acc & ~pwrite) ? rd_nxt : 32'h0000_0000;
    end
  end
  // ****************************************
  // counter copies
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_out <= `PTB_RST_COUNT;
      count_down_flag <= 1'b0;
    end else begin
      count_out <= cnt_r;
      count_down_flag <= dir_r;
    end
  end
endmodule // ptb_time_base
